/* File: shared/dtc_pkg.sv */
package dtc_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_RUN_FLAG   = 8'h88;
  localparam logic [7:0] IDX_MODE       = 8'h89;
  localparam logic [7:0] IDX_LOW_ZERO   = 8'h8a;
  localparam logic [7:0] IDX_LOW_ONE    = 8'h8b;
  localparam logic [7:0] IDX_HIGH_ZERO  = 8'h8c;
  localparam logic [7:0] IDX_HIGH_ONE   = 8'h8d;
  localparam logic [7:0] IDX_IRQ_EN     = 8'ha8;
  localparam logic [7:0] IDX_IRQ_PRIO   = 8'hb8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_REG        = 8'h00;
  localparam logic [7:0] RST_COUNT      = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int MODE_FIELD_W = 4;
  localparam int MODE_GATE    = 3;
  localparam int MODE_CT      = 2;
  localparam int MODE_HI      = 1;
  localparam int BIT_TR0      = 4;
  localparam int BIT_TF0      = 5;
  localparam int BIT_ET0      = 1;
  localparam int BIT_PT0      = 1;
  localparam int BIT_EA       = 7;
  localparam int TIMER_STRIDE = 2;
  localparam int PRE_W        = 5;

  localparam logic [7:0] IP_MASK  = 8'h3f;
  localparam logic [7:0] RUN_MASK = 8'hf0;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [4:0] PRE_MAX  = 5'h1f;

  // ****************************************************************
  // Timing and bus codes
  // ****************************************************************
  localparam int unsigned CLK_PER_TICK = 12;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    MODE_PRESCALE,
    MODE_SIXTEEN,
    MODE_RELOAD,
    MODE_SPLIT
  } dtc_mode_e;

endpackage

/* File: verilog/dtc_timers.sv */
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module dtc_timers #(
  parameter int unsigned PRESCALE = dtc_pkg::CLK_PER_TICK,
  parameter int unsigned AW       = 12
) (
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          count_pin_zero,
  input  wire logic          count_pin_one,
  input  wire logic          run_qualify_pin_zero,
  input  wire logic          run_qualify_pin_one,
  input  wire logic          vector_ack_zero,
  input  wire logic          vector_ack_one,
  output logic               timer_irq_zero,
  output logic               timer_irq_one,
  output logic               overflow_prio_zero,
  output logic               overflow_prio_one,
  output logic               baud_tick_one
);

  // ****************************************************************
  // Constants and checks
  // ****************************************************************
  localparam logic [3:0] DIV_LAST = 4'(PRESCALE - 1);
  localparam int         TICK_GAP = PRESCALE;
  localparam logic [AW-1:0] A_RUN_FLAG  =
    AW'({dtc_pkg::IDX_RUN_FLAG, 2'b00});
  localparam logic [AW-1:0] A_MODE      = AW'({dtc_pkg::IDX_MODE, 2'b00});
  localparam logic [AW-1:0] A_IRQ_EN    =
    AW'({dtc_pkg::IDX_IRQ_EN, 2'b00});
  localparam logic [AW-1:0] A_IRQ_PRIO  =
    AW'({dtc_pkg::IDX_IRQ_PRIO, 2'b00});
  localparam logic [AW-1:0] A_LOW [2]  = '{
    AW'({dtc_pkg::IDX_LOW_ZERO, 2'b00}),
    AW'({dtc_pkg::IDX_LOW_ONE, 2'b00})};
  localparam logic [AW-1:0] A_HIGH [2] = '{
    AW'({dtc_pkg::IDX_HIGH_ZERO, 2'b00}),
    AW'({dtc_pkg::IDX_HIGH_ONE, 2'b00})};

  if (PRESCALE < 2 || PRESCALE > 16) begin : g_bad_prescale
    $error("PRESCALE must lie in 2..16");
  end
  if (AW < 10) begin : g_bad_aw
    $error("AW too small for the register map");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0]  mode_q;
  logic [7:0]  ie_q;
  logic [7:0]  ip_q;
  logic [1:0]  run_q;
  logic [1:0]  tf_q;
  logic [7:0]  lo_q [2];
  logic [7:0]  hi_q [2];
  logic [7:0]  lo_d [2];
  logic [7:0]  hi_d [2];
  logic [1:0]  ovf;
  logic        hi_split_ovf;
  logic [1:0]  tf_set;
  logic [1:0]  en;
  logic [1:0]  prev_q;
  logic [1:0]  fall;
  logic [1:0]  irq_q;
  logic [3:0]  div_q;
  logic        tick;
  logic        baud_q;
  logic        split;

  logic          aw_have_q;
  logic          w_have_q;
  logic [AW-1:0] aw_addr_q;
  logic [31:0]   w_data_q;
  logic          w_lane0_q;
  logic          awready_q;
  logic          wready_q;
  logic          bvalid_q;
  logic [1:0]    bresp_q;
  logic          arready_q;
  logic          rvalid_q;
  logic [31:0]   rdata_q;
  logic [1:0]    rresp_q;
  logic          wr_fire;
  logic          wr_ok;
  logic [1:0]    wsel_lo;
  logic [1:0]    wsel_hi;
  logic          wsel_run;
  logic [7:0]    wbyte;
  logic [7:0]    rd_byte;
  logic          rd_hit;

  function automatic logic addr_hit(input logic [AW-1:0] a);
    addr_hit = (a == A_RUN_FLAG) || (a == A_MODE) || (a == A_IRQ_EN) ||
               (a == A_IRQ_PRIO) || (a == A_LOW[0]) || (a == A_LOW[1]) ||
               (a == A_HIGH[0]) || (a == A_HIGH[1]);
  endfunction

  // ****************************************************************
  // Bus slave: write side
  // ****************************************************************
  // Address and data are held until the response is accepted, so one
  // write at a time; either may arrive first.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      aw_have_q <= 1'b0;
      awready_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && awready_q) begin
      aw_have_q <= 1'b1;
      awready_q <= 1'b0;
      aw_addr_q <= s_axi_awaddr;
    end else if (bvalid_q && s_axi_bready) begin
      aw_have_q <= 1'b0;
    end else if (!aw_have_q) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      w_have_q  <= 1'b0;
      wready_q  <= 1'b0;
      w_data_q  <= '0;
      w_lane0_q <= 1'b0;
    end else if (s_axi_wvalid && wready_q) begin
      w_have_q  <= 1'b1;
      wready_q  <= 1'b0;
      w_data_q  <= s_axi_wdata;
      w_lane0_q <= s_axi_wstrb[0];
    end else if (bvalid_q && s_axi_bready) begin
      w_have_q <= 1'b0;
    end else if (!w_have_q) begin
      wready_q <= 1'b1;
    end
  end

  assign wr_fire  = aw_have_q && w_have_q && !bvalid_q;
  assign wr_ok    = wr_fire && w_lane0_q;
  assign wbyte    = w_data_q[7:0];
  assign wsel_run = wr_ok && (aw_addr_q == A_RUN_FLAG);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= dtc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= addr_hit(aw_addr_q) ? dtc_pkg::RESP_OKAY
                                      : dtc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Bus slave: read side
  // ****************************************************************
  always_comb begin
    rd_hit  = addr_hit(s_axi_araddr);
    rd_byte = 8'h00;
    if (s_axi_araddr == A_RUN_FLAG)
      rd_byte = {tf_q[1], run_q[1], tf_q[0], run_q[0], 4'h0};
    else if (s_axi_araddr == A_MODE)
      rd_byte = mode_q;
    else if (s_axi_araddr == A_IRQ_EN)
      rd_byte = ie_q;
    else if (s_axi_araddr == A_IRQ_PRIO)
      rd_byte = ip_q & dtc_pkg::IP_MASK;
    else if (s_axi_araddr == A_LOW[0])
      rd_byte = lo_q[0];
    else if (s_axi_araddr == A_LOW[1])
      rd_byte = lo_q[1];
    else if (s_axi_araddr == A_HIGH[0])
      rd_byte = hi_q[0];
    else if (s_axi_araddr == A_HIGH[1])
      rd_byte = hi_q[1];
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= dtc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {24'h000000, rd_byte};
      rresp_q   <= rd_hit ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_q <= dtc_pkg::RST_REG;
      ie_q   <= dtc_pkg::RST_REG;
      ip_q   <= dtc_pkg::RST_REG;
    end else if (wr_ok) begin
      if (aw_addr_q == A_MODE)
        mode_q <= wbyte;
      if (aw_addr_q == A_IRQ_EN)
        ie_q <= wbyte;
      if (aw_addr_q == A_IRQ_PRIO)
        ip_q <= wbyte & dtc_pkg::IP_MASK;
    end
  end

  // ****************************************************************
  // Tick divider and pin edge detect
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (sys_rst)
      div_q <= 4'h0;
    else if (div_q == DIV_LAST)
      div_q <= 4'h0;
    else
      div_q <= div_q + 4'h1;
  end
  assign tick = (div_q == DIV_LAST);

  // Reset to low so a pin held low at reset release gives no false edge
  always_ff @(posedge mclk) begin
    if (sys_rst)
      prev_q <= 2'b00;
    else
      prev_q <= {count_pin_one, count_pin_zero};
  end
  assign fall = prev_q & ~{count_pin_one, count_pin_zero};

  assign split = (dtc_pkg::dtc_mode_e'(mode_q[dtc_pkg::MODE_HI -: 2])
                  == dtc_pkg::MODE_SPLIT);

  // ****************************************************************
  // Per-timer counters
  // ****************************************************************
  for (genvar i = 0; i < 2; i++) begin : g_tmr
    localparam int FB = i * dtc_pkg::MODE_FIELD_W;
    logic              gate;
    logic              ct;
    logic              qual;
    logic              frozen;
    logic              hi_en;
    dtc_pkg::dtc_mode_e mode;

    assign gate   = mode_q[FB + dtc_pkg::MODE_GATE];
    assign ct     = mode_q[FB + dtc_pkg::MODE_CT];
    assign mode   = dtc_pkg::dtc_mode_e'(mode_q[FB + dtc_pkg::MODE_HI -: 2]);
    assign qual   = (i == 0) ? run_qualify_pin_zero : run_qualify_pin_one;
    assign frozen = (i == 1) && (mode == dtc_pkg::MODE_SPLIT);
    assign en[i]  = run_q[i] && (!gate || qual) &&
                    (ct ? fall[i] : tick) && !frozen;
    // Split high byte is a pure clock-tick timer under timer one's run
    assign hi_en  = (i == 0) && split && run_q[1] && tick;

    always_comb begin
      lo_d[i] = lo_q[i];
      hi_d[i] = hi_q[i];
      ovf[i]  = 1'b0;
      if (en[i]) begin
        case (mode)
          dtc_pkg::MODE_PRESCALE: begin
            // Top three low bits are left alone and carry no meaning
            lo_d[i][4:0] = lo_q[i][4:0] + 5'h01;
            if (lo_q[i][4:0] == dtc_pkg::PRE_MAX) begin
              hi_d[i] = hi_q[i] + 8'h01;
              ovf[i]  = (hi_q[i] == dtc_pkg::BYTE_MAX);
            end
          end
          dtc_pkg::MODE_SIXTEEN: begin
            {hi_d[i], lo_d[i]} = {hi_q[i], lo_q[i]} + 16'h0001;
            ovf[i] = ({hi_q[i], lo_q[i]} == 16'hffff);
          end
          dtc_pkg::MODE_RELOAD: begin
            if (lo_q[i] == dtc_pkg::BYTE_MAX) begin
              lo_d[i] = hi_q[i];
              ovf[i]  = 1'b1;
            end else begin
              lo_d[i] = lo_q[i] + 8'h01;
            end
          end
          dtc_pkg::MODE_SPLIT: begin
            lo_d[i] = lo_q[i] + 8'h01;
            ovf[i]  = (lo_q[i] == dtc_pkg::BYTE_MAX);
          end
          default: begin
            lo_d[i] = lo_q[i];
          end
        endcase
      end
      if (hi_en)
        hi_d[i] = hi_q[i] + 8'h01;
      if (wr_ok && aw_addr_q == A_LOW[i])
        lo_d[i] = wbyte;
      if (wr_ok && aw_addr_q == A_HIGH[i])
        hi_d[i] = wbyte;
    end

    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        lo_q[i] <= dtc_pkg::RST_COUNT;
        hi_q[i] <= dtc_pkg::RST_COUNT;
      end else begin
        lo_q[i] <= lo_d[i];
        hi_q[i] <= hi_d[i];
      end
    end

    // Set wins over a software clear and over the vector acknowledge
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        run_q[i] <= 1'b0;
        tf_q[i]  <= 1'b0;
      end else begin
        if (wsel_run)
          run_q[i] <= wbyte[dtc_pkg::BIT_TR0 + i * dtc_pkg::TIMER_STRIDE];
        if (tf_set[i])
          tf_q[i] <= 1'b1;
        else if (wsel_run)
          tf_q[i] <= wbyte[dtc_pkg::BIT_TF0 +
                           i * dtc_pkg::TIMER_STRIDE];
        else if ((i == 0) ? vector_ack_zero : vector_ack_one)
          tf_q[i] <= 1'b0;
      end
    end

    always_ff @(posedge mclk) begin
      if (sys_rst)
        irq_q[i] <= 1'b0;
      else
        irq_q[i] <= tf_q[i] && ie_q[dtc_pkg::BIT_EA] &&
                    ie_q[dtc_pkg::BIT_ET0 + i * dtc_pkg::TIMER_STRIDE];
    end
  end

  assign hi_split_ovf = split && run_q[1] && tick &&
                        (hi_q[0] == dtc_pkg::BYTE_MAX);
  assign tf_set[0] = ovf[0];
  assign tf_set[1] = split ? hi_split_ovf : ovf[1];

  always_ff @(posedge mclk) begin
    if (sys_rst)
      baud_q <= 1'b0;
    else
      baud_q <= ovf[1];
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready      = awready_q;
  assign s_axi_wready       = wready_q;
  assign s_axi_bvalid       = bvalid_q;
  assign s_axi_bresp        = bresp_q;
  assign s_axi_arready      = arready_q;
  assign s_axi_rvalid       = rvalid_q;
  assign s_axi_rdata        = rdata_q;
  assign s_axi_rresp        = rresp_q;
  assign timer_irq_zero     = irq_q[0];
  assign timer_irq_one      = irq_q[1];
  assign overflow_prio_zero = ip_q[dtc_pkg::BIT_PT0];
  assign overflow_prio_one  = ip_q[dtc_pkg::BIT_PT0 + dtc_pkg::TIMER_STRIDE];
  assign baud_tick_one      = baud_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_tick_period;
    @(posedge mclk) disable iff (sys_rst)
    tick |=> !tick ##(TICK_GAP - 1) tick;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("tick spacing differs from the prescale count");

  property p_event_count;
    @(posedge mclk) disable iff (sys_rst)
    (mode_q[3:0] == 4'h5 && run_q[0] && fall[0] && !wr_fire)
      |=> lo_q[0] == $past(lo_q[0]) + 8'h01;
  endproperty
  a_event_count: assert property (p_event_count)
    else $error("falling edge did not advance low byte zero");

  property p_reload;
    @(posedge mclk) disable iff (sys_rst)
    (mode_q[1:0] == 2'h2 && en[0] && lo_q[0] == 8'hff && !wr_fire)
      |=> lo_q[0] == $past(hi_q[0]) && tf_q[0] && hi_q[0] == $past(hi_q[0]);
  endproperty
  a_reload: assert property (p_reload)
    else $error("reload did not copy high byte or set flag");

  property p_prescale_ovf;
    @(posedge mclk) disable iff (sys_rst)
    (mode_q[1:0] == 2'h0 && en[0] && hi_q[0] == 8'hff &&
     lo_q[0][4:0] == 5'h1f && !wr_fire) |=> tf_q[0] && hi_q[0] == 8'h00;
  endproperty
  a_prescale_ovf: assert property (p_prescale_ovf)
    else $error("13-bit rollover did not set flag");

  property p_frozen;
    @(posedge mclk) disable iff (sys_rst)
    (mode_q[5:4] == 2'h3 && !wr_fire) |=>
      lo_q[1] == $past(lo_q[1]) && hi_q[1] == $past(hi_q[1]);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("timer one moved in mode 11");

  property p_gate;
    @(posedge mclk) disable iff (sys_rst)
    (mode_q[3] && !run_qualify_pin_zero) || !run_q[0] |-> !en[0];
  endproperty
  a_gate: assert property (p_gate)
    else $error("timer zero counted while gated off");

  property p_split_flag;
    @(posedge mclk) disable iff (sys_rst)
    (split && ovf[1] && !hi_split_ovf && !wsel_run && !tf_q[1])
      |=> !tf_q[1] && baud_q;
  endproperty
  a_split_flag: assert property (p_split_flag)
    else $error("timer one overflow set its flag while split");

  property p_ack_clear;
    @(posedge mclk) disable iff (sys_rst)
    (vector_ack_zero && !tf_set[0] && !wsel_run) |=> !tf_q[0];
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("vector acknowledge did not clear flag zero");

  property p_irq;
    @(posedge mclk) disable iff (sys_rst)
    (tf_q[1] && ie_q[7] && ie_q[3]) |=> timer_irq_one;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled flag one gave no interrupt");

  property p_write_wins;
    @(posedge mclk) disable iff (sys_rst)
    (wr_ok && aw_addr_q == A_LOW[0]) |=> lo_q[0] == $past(wbyte);
  endproperty
  a_write_wins: assert property (p_write_wins)
    else $error("count byte write lost to increment");

endmodule

/* File: test/dtc_pin_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Far-side pins: count inputs and gate inputs
// ****************************************************************
module dtc_pin_model (
  input  wire logic mclk,
  output logic      count_pin_zero,
  output logic      count_pin_one,
  output logic      run_qualify_pin_zero,
  output logic      run_qualify_pin_one
);
  initial begin
    count_pin_zero = 1'b1;
    count_pin_one = 1'b1;
    run_qualify_pin_zero = 1'b0;
    run_qualify_pin_one = 1'b0;
  end

  // Each level lasts whole clocks so the per-clock sampler sees it
  task automatic fall(input logic which, input int n, input int hold);
    repeat (n) begin
      @(posedge mclk);
      if (which) count_pin_one <= 1'b0;
      else count_pin_zero <= 1'b0;
      repeat (hold) @(posedge mclk);
      if (which) count_pin_one <= 1'b1;
      else count_pin_zero <= 1'b1;
      repeat (hold) @(posedge mclk);
    end
  endtask

  task automatic gate(input logic which, input logic lvl);
    @(posedge mclk);
    if (which) run_qualify_pin_one <= lvl;
    else run_qualify_pin_zero <= lvl;
  endtask
endmodule

/* File: test/dtc_timers_tb.sv */
`timescale 1ns/1ps
module dtc_timers_tb;
  logic        mclk, sys_rst, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0]  bresp, rresp;
  logic        c0, c1, g0, g1, ack0, irq0, irq1, pr0, pr1, baud;
  logic [7:0]  v;
  int          err_total, n_tests, baud_cnt;

  dtc_timers #(.PRESCALE(4)) i_dtc_timers (.mclk(mclk), .sys_rst(sys_rst),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .count_pin_zero(c0),
    .count_pin_one(c1), .run_qualify_pin_zero(g0), .run_qualify_pin_one(g1),
    .vector_ack_zero(ack0), .vector_ack_one(1'b0), .timer_irq_zero(irq0),
    .timer_irq_one(irq1), .overflow_prio_zero(pr0),
    .overflow_prio_one(pr1), .baud_tick_one(baud));
  dtc_pin_model i_dtc_pin_model (.mclk(mclk), .count_pin_zero(c0),
    .count_pin_one(c1), .run_qualify_pin_zero(g0), .run_qualify_pin_one(g1));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) if (baud === 1'b1) baud_cnt <= baud_cnt + 1;

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected t=%0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [7:0] got, input int lo, input int hi);
    n_tests++;
    if (^got === 1'bx || got < lo || got > hi) begin
      err_total++;
      $display("unexpected t=%0t count %h out of range", $time, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge mclk);
    awa <= {2'h0, a, 2'h0};
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge mclk);
      if (awv && awr) begin ta = 1'b1; awv <= 1'b0; end
      if (wv && wr_rdy) begin tw = 1'b1; wv <= 1'b0; end
    end
    do @(posedge mclk); while (bv !== 1'b1);
    br <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    ara <= {2'h0, a, 2'h0};
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge mclk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge mclk); while (rv !== 1'b1);
    d = rd[7:0];
    rr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    rdr(a, v);
    chk({24'h0, v & m}, {24'h0, e});
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_map;
    rchk(dtc_pkg::IDX_MODE, 8'hff, 8'h00);
    rchk(dtc_pkg::IDX_RUN_FLAG, 8'hff, 8'h00);
    rchk(dtc_pkg::IDX_IRQ_EN, 8'hff, 8'h00);
    rchk(dtc_pkg::IDX_IRQ_PRIO, 8'hff, 8'h00);
    rdr(8'h90, v);
    chk({30'h0, rresp}, {30'h0, dtc_pkg::RESP_SLVERR});
    wr(8'h90, 8'h55);
    chk({30'h0, bresp}, {30'h0, dtc_pkg::RESP_SLVERR});
  endtask

  // Mode 00 on pin events: 5-bit prescaler rolls into the high byte
  task automatic t_mode0_events;
    wr(dtc_pkg::IDX_MODE, 8'h04);
    wr(dtc_pkg::IDX_LOW_ZERO, 8'h1e);
    wr(dtc_pkg::IDX_HIGH_ZERO, 8'hff);
    wr(dtc_pkg::IDX_RUN_FLAG, 8'h10);
    i_dtc_pin_model.fall(1'b0, 3, 2);
    rchk(dtc_pkg::IDX_LOW_ZERO, 8'h1f, 8'h01);
    rchk(dtc_pkg::IDX_HIGH_ZERO, 8'hff, 8'h00);
    rchk(dtc_pkg::IDX_RUN_FLAG, 8'hf0, 8'h30);
  endtask

  task automatic t_gate_mode1;
    wr(dtc_pkg::IDX_RUN_FLAG, 8'h00);
    wr(dtc_pkg::IDX_MODE, 8'h0d);
    wr(dtc_pkg::IDX_LOW_ZERO, 8'hff);
    wr(dtc_pkg::IDX_HIGH_ZERO, 8'h00);
    wr(dtc_pkg::IDX_RUN_FLAG, 8'h10);
    i_dtc_pin_model.fall(1'b0, 2, 1);
    rchk(dtc_pkg::IDX_LOW_ZERO, 8'hff, 8'hff);
    i_dtc_pin_model.gate(1'b0, 1'b1);
    i_dtc_pin_model.fall(1'b0, 2, 3);
    rchk(dtc_pkg::IDX_LOW_ZERO, 8'hff, 8'h01);
    rchk(dtc_pkg::IDX_HIGH_ZERO, 8'hff, 8'h01);
  endtask

  task automatic t_flags_irq;
    wr(dtc_pkg::IDX_RUN_FLAG, 8'h20);
    wr(dtc_pkg::IDX_IRQ_EN, 8'h02);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq0}, 32'h0);
    wr(dtc_pkg::IDX_IRQ_EN, 8'h82);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq0}, 32'h1);
    ack0 <= 1'b1;
    @(posedge mclk);
    ack0 <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({31'h0, irq0}, 32'h0);
    rchk(dtc_pkg::IDX_RUN_FLAG, 8'hff, 8'h00);
    wr(dtc_pkg::IDX_IRQ_PRIO, 8'hff);
    rchk(dtc_pkg::IDX_IRQ_PRIO, 8'hff, dtc_pkg::IP_MASK);
    chk({30'h0, pr1, pr0}, 32'h3);
  endtask

  task automatic t_reload_freeze;
    int b;
    wr(dtc_pkg::IDX_MODE, 8'h60);
    wr(dtc_pkg::IDX_HIGH_ONE, 8'hf0);
    wr(dtc_pkg::IDX_LOW_ONE, 8'hff);
    wr(dtc_pkg::IDX_RUN_FLAG, 8'h40);
    b = baud_cnt;
    i_dtc_pin_model.fall(1'b1, 1, 3);
    chk(baud_cnt - b, 32'h1);
    rchk(dtc_pkg::IDX_LOW_ONE, 8'hff, 8'hf0);
    rchk(dtc_pkg::IDX_HIGH_ONE, 8'hff, 8'hf0);
    rchk(dtc_pkg::IDX_RUN_FLAG, 8'hf0, 8'hc0);
    wr(dtc_pkg::IDX_IRQ_EN, 8'h8a);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq1}, 32'h1);
    wr(dtc_pkg::IDX_MODE, 8'h70);
    i_dtc_pin_model.fall(1'b1, 2, 1);
    rchk(dtc_pkg::IDX_LOW_ONE, 8'hff, 8'hf0);
  endtask

  // Split mode: high byte of timer zero ticks every 4 clocks on run one
  task automatic t_split_timing;
    wr(dtc_pkg::IDX_RUN_FLAG, 8'h00);
    wr(dtc_pkg::IDX_MODE, 8'h03);
    wr(dtc_pkg::IDX_LOW_ZERO, 8'h00);
    wr(dtc_pkg::IDX_HIGH_ZERO, 8'h00);
    wr(dtc_pkg::IDX_RUN_FLAG, 8'h40);
    repeat (40) @(posedge mclk);
    wr(dtc_pkg::IDX_RUN_FLAG, 8'h00);
    rdr(dtc_pkg::IDX_HIGH_ZERO, v);
    chk_rng(v, 9, 12);
    rchk(dtc_pkg::IDX_LOW_ZERO, 8'hff, 8'h00);
  endtask

  initial begin
    {awv, wv, br, arv, rr, ack0} = '0;
    {awa, ara, wd} = '0;
    {err_total, n_tests, baud_cnt} = '0;
    sys_rst = 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_reset_map();
    t_mode0_events();
    t_gate_mode1();
    t_flags_irq();
    t_reload_freeze();
    t_split_timing();
    results();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    results();
  end
endmodule
